// ===== rtl/gcsp_pkg.sv
// Constants and types shared by the gauge command and status port
package gcsp_pkg;
  // Word offsets on the two-wire bus (low byte even, high byte odd)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_RATE      = 8'h02;
  localparam logic [7:0] REG_TTE_RATE  = 8'h04;
  localparam logic [7:0] REG_TEMP      = 8'h06;
  localparam logic [7:0] REG_VOLT      = 8'h08;
  localparam logic [7:0] REG_FLAGS     = 8'h0A;
  localparam logic [7:0] REG_NOM_REM   = 8'h0C;
  localparam logic [7:0] REG_NOM_FULL  = 8'h0E;
  localparam logic [7:0] REG_REM       = 8'h10;
  localparam logic [7:0] REG_FULL      = 8'h12;
  localparam logic [7:0] REG_CUR       = 8'h14;
  localparam logic [7:0] REG_TTE       = 8'h16;
  localparam logic [7:0] REG_TTF       = 8'h18;
  localparam logic [7:0] REG_STBY      = 8'h1A;
  // Control subcommands
  localparam logic [15:0] CMD_STATUS   = 16'h0000;
  localparam logic [15:0] CMD_CHEM     = 16'h0008;
  localparam logic [15:0] CMD_REST     = 16'h000C;
  localparam logic [15:0] CMD_INSERT   = 16'h000D;
  localparam logic [15:0] CMD_REMOVE   = 16'h000E;
  localparam logic [15:0] CMD_HIB_SET  = 16'h0011;
  localparam logic [15:0] CMD_HIB_CLR  = 16'h0012;
  localparam logic [15:0] CMD_REV      = 16'h001F;
  localparam logic [15:0] CMD_SEAL     = 16'h0020;
  localparam logic [15:0] CMD_LEARN    = 16'h0030;
  localparam logic [15:0] CMD_RESET    = 16'h0041;
  // Control status word bit positions
  localparam int CS_SEALED = 13;
  localparam int CS_REST_DONE = 9;
  localparam int CS_REST_FAIL = 8;
  localparam int CS_INIT_DONE = 7;
  localparam int CS_HIB = 6;
  localparam int CS_LEARN = 0;
  // Status flag word bit positions
  localparam int FL_HOT_CHG = 15;
  localparam int FL_HOT_DSG = 14;
  localparam int FL_CHG_BLOCK = 11;
  localparam int FL_PRESENT = 3;
  localparam int FL_CHARGE_THRESHOLD_ONE_FLAG = 2;
  localparam int FL_SHUTDOWN = 1;
  localparam int FL_DSG = 0;
  // Values
  localparam logic [15:0] VOLT_MAX_MV = 16'h1770;
  localparam logic [15:0] WORD_NONE   = 16'hFFFF;
  localparam logic [15:0] TTE_MAX     = 16'hFFFE;
  localparam logic [8:0]  STBY_OLD_W  = 9'h0EE;
  localparam logic [8:0]  STBY_NEW_W  = 9'h012;
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam int REST_PULSE_MS = 8;
  localparam int REST_PULSE_CYC = CLK_HZ / 1000 * REST_PULSE_MS;
  // Control word read-back selection
  localparam logic [1:0] CV_STATUS = 2'h0;
  localparam logic [1:0] CV_CHEM   = 2'h1;
  localparam logic [1:0] CV_REV    = 2'h2;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_WDATA = 6'b000100,
    ST_SACK  = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_MACK  = 6'b100000
  } gcsp_bus_e;
endpackage

// ===== rtl/gcsp_top.sv
// Gauge command interpreter and result registers behind a two-wire slave
`timescale 1ns/1ps
`default_nettype none
module gcsp_top
  import gcsp_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR      = 7'h55,   // Arbitrary bus address
  parameter logic [15:0] CHEM_CODE     = 16'h0123, // Arbitrary value
  parameter logic [15:0] STORAGE_REV   = 16'h0000,
  parameter logic [15:0] LEARN_CURRENT = 16'h0190,
  parameter logic [15:0] INIT_STANDBY  = 16'h000A,
  parameter logic [15:0] DEADBAND      = 16'h0005,
  parameter int          TICK_CYCLES   = TICK_CYC,
  parameter int          PULSE_CYCLES  = REST_PULSE_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Two-wire bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_data_out,
  output logic             sda_oe_n_out,
  // Estimator results
  input  wire logic [15:0] volt_meas_in,
  input  wire logic [15:0] sensor_temp_in,
  input  wire logic [15:0] ext_temp_in,
  input  wire logic [15:0] nom_rem_in,
  input  wire logic [15:0] nom_full_in,
  input  wire logic [15:0] rem_in,
  input  wire logic [15:0] full_in,
  input  wire logic [15:0] est_current_in,
  input  wire logic [15:0] tte_in,
  input  wire logic [15:0] ttf_in,
  input  wire logic [15:0] at_rate_tte_in,
  // Estimator status
  input  wire logic        init_done_in,
  input  wire logic        charging_in,
  input  wire logic        discharging_in,
  input  wire logic        charge_block_flag_in,
  input  wire logic        hot_while_charging_flag_in,
  input  wire logic        hot_while_discharging_flag_in,
  input  wire logic        system_shutdown_flag_in,
  input  wire logic        charge_threshold_one_flag_reached_in,
  input  wire logic        pack_sense_in,
  input  wire logic        sleep_in,
  input  wire logic        wake_in,
  input  wire logic        discharge_end_in,
  // Configuration
  input  wire logic        auto_insert_detect_en_in,
  input  wire logic        host_temp_write_en_in,
  input  wire logic        temp_source_select_in,
  input  wire logic        low_battery_irq_en_in,
  // Results toward the gauge core and system
  output logic             soc_int_out,
  output logic             rest_measure_out,
  output logic             hibernate_out,
  output logic             device_reset_out,
  output logic [15:0]      accum_current_out,
  output logic [15:0]      host_set_rate_out,
  output logic [15:0]      gauge_temp_out
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);

  logic [1:0] scl_sy, sda_sy;
  logic       scl_q, sda_q;
  gcsp_bus_e  st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx, ptr, wr_addr, wr_data, rd_byte;
  logic       drive, rd_mode, first, host_nack, wr_stb;
  logic [7:0] ctl_lo, temp_lo;
  logic [15:0] cmd, host_temp, rd_word, ctrl_word, status_word, flags;
  logic       cmd_stb, soft_rst, grst, sealed, learn, hib_req;
  logic       pack_present, learn_done, rest_pend, rest_done, rest_fail;
  logic [1:0] ctrl_view;
  logic [TW-1:0] tick_cnt;
  logic [PW-1:0] pulse_cnt;
  logic       tick, soc_tog, hot_c_q, hot_d_q, sdn_q;
  logic [15:0] tte_rate, volt, tte, ttf, stby, stby_pend;
  logic [1:0] streak;
  logic [24:0] next_stby;
  logic       qual;

  assign grst = !rst_n_in || soft_rst;
  assign sda_data_out = 1'b0;
  assign sda_oe_n_out = !drive;

  // Pin synchronisers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else if (ce_in) begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_q  <= scl_sy[1];
      sda_q  <= sda_sy[1];
    end
  end

  wire scl_rise = scl_sy[1] && !scl_q;
  wire scl_fall = !scl_sy[1] && scl_q;
  wire bus_start = scl_sy[1] && scl_q && sda_q && !sda_sy[1];
  wire bus_stop = scl_sy[1] && scl_q && !sda_q && sda_sy[1];

  // Bus slave; bus state survives the soft reset so an ack is not cut short
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      drive <= 1'b0;
      rd_mode <= 1'b0;
      first <= 1'b0;
      host_nack <= 1'b0;
      wr_stb <= 1'b0;
    end else if (ce_in) begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        st <= ST_ADDR;
        bit_cnt <= 4'h0;
        drive <= 1'b0;
      end else if (bus_stop) begin
        st <= ST_IDLE;
        drive <= 1'b0;
      end else if (scl_rise) begin
        if (st == ST_ADDR || st == ST_WDATA) begin
          shreg <= {shreg[6:0], sda_sy[1]};
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (st == ST_MACK) host_nack <= sda_sy[1];
      end else if (scl_fall) begin
        unique case (st)
          ST_IDLE: ;
          ST_ADDR: if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == DEV_ADDR) begin
              st <= ST_SACK;
              drive <= 1'b1;
              rd_mode <= shreg[0];
              first <= !shreg[0];
            end else st <= ST_IDLE;
          end
          ST_WDATA: if (bit_cnt == 4'h8) begin
            st <= ST_SACK;
            drive <= 1'b1;
            first <= 1'b0;
            if (first) ptr <= shreg;
            else begin
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
            end
          end
          ST_SACK, ST_MACK: begin
            if (st == ST_MACK && host_nack) begin
              st <= ST_IDLE;
            end else if (rd_mode) begin
              st <= ST_RDATA;
              drive <= !rd_byte[7];
              tx <= {rd_byte[6:0], 1'b0};
              ptr <= ptr + 8'h01;
              bit_cnt <= 4'h1;
            end else begin
              st <= ST_WDATA;
              drive <= 1'b0;
              bit_cnt <= 4'h0;
            end
          end
          ST_RDATA: if (bit_cnt == 4'h8) begin
            st <= ST_MACK;
            drive <= 1'b0;
          end else begin
            drive <= !tx[7];
            tx <= {tx[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        endcase
      end
    end
  end

  // Read-back mux; low byte at the even offset
  always_comb begin
    unique case ({ptr[7:1], 1'b0})
      REG_CTRL:     rd_word = ctrl_word;
      REG_RATE:     rd_word = host_set_rate_out;
      REG_TTE_RATE: rd_word = tte_rate;
      REG_TEMP:     rd_word = gauge_temp_out;
      REG_VOLT:     rd_word = volt;
      REG_FLAGS:    rd_word = flags;
      REG_NOM_REM:  rd_word = nom_rem_in;
      REG_NOM_FULL: rd_word = nom_full_in;
      REG_REM:      rd_word = rem_in;
      REG_FULL:     rd_word = full_in;
      REG_CUR:      rd_word = est_current_in;
      REG_TTE:      rd_word = tte;
      REG_TTF:      rd_word = ttf;
      REG_STBY:     rd_word = stby;
      default:      rd_word = 16'h0000;
    endcase
    rd_byte = ptr[0] ? rd_word[15:8] : rd_word[7:0];
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[CS_SEALED] = sealed;
    status_word[CS_REST_DONE] = rest_done;
    status_word[CS_REST_FAIL] = rest_fail;
    status_word[CS_INIT_DONE] = init_done_in;
    status_word[CS_HIB] = hib_req;
    status_word[CS_LEARN] = learn;
    unique case (ctrl_view)
      CV_CHEM: ctrl_word = CHEM_CODE;
      CV_REV:  ctrl_word = STORAGE_REV;
      default: ctrl_word = status_word;
    endcase
  end

  // Register writes; control and temperature words take effect on their high byte
  always_ff @(posedge clk_in) begin
    if (grst) begin
      ctl_lo <= 8'h00;
      temp_lo <= 8'h00;
      cmd <= CMD_STATUS;
      cmd_stb <= 1'b0;
      host_set_rate_out <= 16'h0000;
      host_temp <= 16'h0000;
    end else if (ce_in) begin
      cmd_stb <= 1'b0;
      if (wr_stb) begin
        unique case (wr_addr)
          REG_CTRL: ctl_lo <= wr_data;
          8'h01: begin
            cmd <= {wr_data, ctl_lo};
            cmd_stb <= 1'b1;
          end
          REG_RATE: host_set_rate_out[7:0] <= wr_data;
          8'h03: host_set_rate_out[15:8] <= wr_data;
          REG_TEMP: temp_lo <= wr_data;
          8'h07: if (host_temp_write_en_in) host_temp <= {wr_data, temp_lo};
          default: ;
        endcase
      end
    end
  end

  wire exec = ce_in && cmd_stb;

  // Subcommand effects on access, presence, hibernate and learning
  always_ff @(posedge clk_in) begin
    if (grst) begin
      sealed <= 1'b0;
      learn <= 1'b0;
      learn_done <= 1'b0;
      hib_req <= 1'b0;
      hibernate_out <= 1'b0;
      pack_present <= 1'b0;
      ctrl_view <= CV_STATUS;
    end else if (ce_in) begin
      if (auto_insert_detect_en_in) pack_present <= pack_sense_in;
      else if (cmd_stb && cmd == CMD_INSERT) pack_present <= 1'b1;
      else if (cmd_stb && cmd == CMD_REMOVE) pack_present <= 1'b0;
      if (cmd_stb && cmd == CMD_HIB_CLR) begin
        hib_req <= 1'b0;
        hibernate_out <= 1'b0;
      end else if (hibernate_out && wake_in) begin
        hibernate_out <= 1'b0;
        // A set arriving on the wake cycle is kept
        hib_req <= cmd_stb && cmd == CMD_HIB_SET;
      end else begin
        if (cmd_stb && cmd == CMD_HIB_SET) hib_req <= 1'b1;
        if (hib_req && sleep_in) hibernate_out <= 1'b1;
      end
      if (cmd_stb) begin
        unique case (cmd)
          CMD_CHEM: ctrl_view <= CV_CHEM;
          CMD_REV:  ctrl_view <= CV_REV;
          default:  ctrl_view <= CV_STATUS;
        endcase
      end
      if (cmd_stb && cmd == CMD_SEAL) sealed <= 1'b1;
      if (cmd_stb && cmd == CMD_LEARN && !sealed) begin
        learn <= 1'b1;
        learn_done <= 1'b0;
      end else if (learn && discharging_in && discharge_end_in) begin
        learn_done <= 1'b1;
      end
    end
  end

  // Reset subcommand; held apart from the reset it causes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      soft_rst <= 1'b0;
      device_reset_out <= 1'b0;
    end else if (ce_in) begin
      soft_rst <= cmd_stb && cmd == CMD_RESET && !sealed && !soft_rst;
      device_reset_out <= cmd_stb && cmd == CMD_RESET && !sealed && !soft_rst;
    end
  end

  // One-second tick and the rest-voltage sequence
  always_ff @(posedge clk_in) begin
    if (grst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
      rest_pend <= 1'b0;
      rest_done <= 1'b0;
      rest_fail <= 1'b0;
      rest_measure_out <= 1'b0;
      pulse_cnt <= '0;
    end else if (ce_in) begin
      tick <= tick_cnt == TW'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
      rest_measure_out <= 1'b0;
      if (pulse_cnt != '0) pulse_cnt <= pulse_cnt - 1'b1;
      if (cmd_stb && cmd == CMD_REST && init_done_in) begin
        rest_done <= 1'b0;
        rest_fail <= charge_block_flag_in;
        rest_pend <= !charge_block_flag_in;
      end else if (tick && rest_pend) begin
        rest_pend <= 1'b0;
        rest_done <= 1'b1;
        rest_measure_out <= 1'b1;
        pulse_cnt <= PW'(PULSE_CYCLES);
      end
    end
  end

  // Charge interrupt: event toggles plus the rest-voltage pulse
  always_ff @(posedge clk_in) begin
    if (grst) begin
      soc_tog <= 1'b0;
      hot_c_q <= 1'b0;
      hot_d_q <= 1'b0;
      sdn_q <= 1'b0;
      soc_int_out <= 1'b0;
    end else if (ce_in) begin
      hot_c_q <= hot_while_charging_flag_in;
      hot_d_q <= hot_while_discharging_flag_in;
      sdn_q <= system_shutdown_flag_in;
      soc_tog <= soc_tog ^ (hot_while_charging_flag_in && !hot_c_q)
                 ^ (hot_while_discharging_flag_in && !hot_d_q)
                 ^ (system_shutdown_flag_in && !sdn_q);
      soc_int_out <= soc_tog ^ (pulse_cnt != '0);
    end
  end

  // Result words
  always_ff @(posedge clk_in) begin
    if (grst) begin
      volt <= 16'h0000;
      tte <= WORD_NONE;
      ttf <= WORD_NONE;
      tte_rate <= WORD_NONE;
      flags <= 16'h0000;
      gauge_temp_out <= 16'h0000;
      accum_current_out <= 16'h0000;
    end else if (ce_in) begin
      volt <= (volt_meas_in > VOLT_MAX_MV) ? VOLT_MAX_MV : volt_meas_in;
      tte <= discharging_in ? tte_in : WORD_NONE;
      ttf <= charging_in ? ttf_in : WORD_NONE;
      if (tick) begin
        if (host_set_rate_out == 16'h0000) tte_rate <= WORD_NONE;
        else tte_rate <= (at_rate_tte_in > TTE_MAX) ? TTE_MAX : at_rate_tte_in;
      end
      flags <= 16'h0000;
      flags[FL_HOT_CHG] <= hot_while_charging_flag_in;
      flags[FL_HOT_DSG] <= hot_while_discharging_flag_in;
      flags[FL_CHG_BLOCK] <= charge_block_flag_in;
      flags[FL_PRESENT] <= pack_present;
      flags[FL_CHARGE_THRESHOLD_ONE_FLAG] <= charge_threshold_one_flag_reached_in && low_battery_irq_en_in;
      flags[FL_SHUTDOWN] <= system_shutdown_flag_in;
      flags[FL_DSG] <= discharging_in;
      if (host_temp_write_en_in) gauge_temp_out <= host_temp;
      else gauge_temp_out <= temp_source_select_in ? ext_temp_in : sensor_temp_in;
      if (learn && discharging_in)
        accum_current_out <= learn_done ? 16'h0000 : LEARN_CURRENT;
      else accum_current_out <= est_current_in;
    end
  end

  // Standby filter; a sample is held back one tick so the last one can be dropped
  assign qual = $signed(est_current_in) > $signed(DEADBAND)
                && $signed({est_current_in[15], est_current_in})
                   <= $signed({INIT_STANDBY, 1'b0});
  // Operands widened first so the products cannot wrap at 16 bits
  assign next_stby = $signed({{9{stby[15]}}, stby}) * $signed({16'h0000, STBY_OLD_W})
                     + $signed({{9{stby_pend[15]}}, stby_pend})
                       * $signed({16'h0000, STBY_NEW_W});

  always_ff @(posedge clk_in) begin
    if (grst) begin
      stby <= INIT_STANDBY;
      stby_pend <= 16'h0000;
      streak <= 2'h0;
    end else if (ce_in && tick) begin
      if (qual) begin
        if (streak == 2'h2) stby <= next_stby[23:8];
        stby_pend <= est_current_in;
        if (streak != 2'h2) streak <= streak + 2'h1;
      end else begin
        streak <= 2'h0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (grst);

  property p_volt_clamp;
    ce_in && volt_meas_in > VOLT_MAX_MV |=> volt == VOLT_MAX_MV;
  endproperty
  a_volt_clamp: assert property (p_volt_clamp) else $error("voltage not clamped");
  property p_tte_none;
    ce_in && !discharging_in |=> tte == WORD_NONE;
  endproperty
  a_tte_none: assert property (p_tte_none) else $error("tte not all ones");
  property p_ttf_none;
    ce_in && !charging_in |=> ttf == WORD_NONE;
  endproperty
  a_ttf_none: assert property (p_ttf_none) else $error("ttf not all ones");
  property p_rest_fail;
    exec && cmd == CMD_REST && init_done_in && charge_block_flag_in |=> rest_fail && !rest_pend;
  endproperty
  a_rest_fail: assert property (p_rest_fail) else $error("fail bit not set");
  property p_rest_tick;
    ce_in && tick && rest_pend && !cmd_stb |=> rest_measure_out && rest_done ##2 soc_int_out != soc_tog;
  endproperty
  a_rest_tick: assert property (p_rest_tick) else $error("measurement not taken");
  property p_sealed_learn;
    exec && cmd == CMD_LEARN && sealed && !learn |=> !learn;
  endproperty
  a_sealed_learn: assert property (p_sealed_learn) else $error("learn accepted sealed");
  property p_shutdown_toggle;
    ce_in && system_shutdown_flag_in && !sdn_q && !hot_c_q && !hot_d_q
      && !hot_while_charging_flag_in && !hot_while_discharging_flag_in |=> soc_tog != $past(soc_tog);
  endproperty
  a_shutdown_toggle: assert property (p_shutdown_toggle) else $error("no toggle");
  property p_insert;
    exec && cmd == CMD_INSERT && !auto_insert_detect_en_in |=> pack_present;
  endproperty
  a_insert: assert property (p_insert) else $error("insert ignored");
  property p_rate_zero;
    ce_in && tick && host_set_rate_out == 16'h0000 |=> tte_rate == WORD_NONE;
  endproperty
  a_rate_zero: assert property (p_rate_zero) else $error("rate word wrong");
  property p_hib_clr;
    exec && cmd == CMD_HIB_CLR |=> !hib_req && !hibernate_out;
  endproperty
  a_hib_clr: assert property (p_hib_clr) else $error("hibernate kept");

  c_rest: cover property (ce_in && rest_measure_out);
  c_read: cover property (ce_in && st == ST_MACK && scl_fall && !host_nack);
  c_learn_done: cover property (learn && learn_done && discharging_in);
  c_hib: cover property (hibernate_out && wake_in);
endmodule
`default_nettype wire

// ===== tb/gcsp_host_model.sv
// Host bus master model for the two-wire pins
`timescale 1ns/1ps
`default_nettype none
module gcsp_host_model (
  // Bus pins
  output logic      scl_out,
  output wire logic sda_out,
  input  wire logic dev_oe_n_in
);
  localparam realtime Q = 31.25;
  logic low = 1'b0;
  initial scl_out = 1'b1;
  // Pull-up: a released line reads high
  assign sda_out = !(low || !dev_oe_n_in);
  task automatic bit_io(input logic b, output logic r);
    low = !b;
    #Q scl_out = 1'b1;
    #Q r = sda_out;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic xfer(input logic [7:0] b, input logic ai, output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ai, ao);
  endtask
  // Start is (0,1), stop is (1,0); SCL idles high after a stop
  task automatic frame(input logic a, input logic b);
    low = a;
    #Q scl_out = 1'b1;
    #Q low = b;
    #Q scl_out = !b;
    #Q;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Bench: host bus sequences against the gauge command port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gcsp_pkg::*;
  localparam logic [15:0] CHEM = 16'h0ABC; // Arbitrary value
  logic        clk_in = 1'b0, rst_n_in = 1'b0, s_d = 1'b0;
  logic [15:0] f = 16'h8000, w [11];
  wire logic   scl, sda, oe_n, soc, meas, drst, hib;
  wire logic [15:0] acc;
  logic        irq_en = 1'b1;
  int          errors = 0, check_count = 0, cyc = 0, n_meas = 0, n_rst = 0, n_soc = 0;
  always #4 clk_in = !clk_in;
  gcsp_host_model host (.scl_out(scl), .sda_out(sda), .dev_oe_n_in(oe_n));
  gcsp_top #(.CHEM_CODE(CHEM), .TICK_CYCLES(200), .PULSE_CYCLES(20)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(f[15]), .scl_in(scl), .sda_in(sda),
    .sda_data_out(), .sda_oe_n_out(oe_n), .volt_meas_in(w[0]), .sensor_temp_in(w[1]),
    .ext_temp_in(w[2]), .nom_rem_in(w[3]), .nom_full_in(w[4]), .rem_in(w[5]), .full_in(w[6]),
    .est_current_in(w[7]), .tte_in(w[8]), .ttf_in(w[9]), .at_rate_tte_in(w[10]),
    .init_done_in(f[0]), .charging_in(f[1]), .discharging_in(f[2]), .sleep_in(f[9]),
    .charge_block_flag_in(f[3]), .hot_while_charging_flag_in(f[4]), .wake_in(f[10]),
    .hot_while_discharging_flag_in(f[5]), .system_shutdown_flag_in(f[6]),
    .charge_threshold_one_flag_reached_in(f[7]), .pack_sense_in(f[8]), .discharge_end_in(f[11]),
    .auto_insert_detect_en_in(f[12]), .host_temp_write_en_in(f[13]),
    .temp_source_select_in(f[14]), .low_battery_irq_en_in(irq_en), .soc_int_out(soc),
    .rest_measure_out(meas), .hibernate_out(hib), .device_reset_out(drst),
    .accum_current_out(acc), .host_set_rate_out(), .gauge_temp_out());
  // Pulses and level changes counted mid-cycle, clear of the launching edge
  always @(negedge clk_in) begin
    cyc++;
    n_meas += int'(meas === 1'b1);
    n_rst += int'(drst === 1'b1);
    n_soc += int'(rst_n_in && soc !== s_d);
    s_d = soc;
    if (cyc == 60000) final_report(1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    errors += int'(got !== exp);
    if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic bus(input logic [7:0] off, input logic [15:0] d, input logic is_rd);
    logic [15:0] v;
    logic a;
    host.frame(1'b0, 1'b1);
    host.xfer(8'hAA, 1'b1, v[7:0], a);
    host.xfer(off, 1'b1, v[7:0], a);
    if (is_rd) host.frame(1'b0, 1'b1);
    if (is_rd) host.xfer(8'hAB, 1'b1, v[7:0], a);
    host.xfer(is_rd ? 8'hFF : d[7:0], !is_rd, v[7:0], a);
    host.xfer(is_rd ? 8'hFF : d[15:8], 1'b1, v[15:8], a);
    host.frame(1'b1, 1'b0);
    if (is_rd) chk(v, d);
  endtask
  task automatic cq(input logic [15:0] c, input logic [15:0] e);
    bus(REG_CTRL, c, 1'b0);
    bus(REG_CTRL, e, 1'b1);
  endtask
  task automatic final_report(input int extra);
    errors += extra;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    foreach (w[i]) w[i] = 16'h0100 + 16'(i);
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    bus(REG_TTE, WORD_NONE, 1'b1);
    bus(REG_TTF, WORD_NONE, 1'b1);
    @(negedge clk_in) {f[2], w[0]} = {1'b1, 16'h2000};
    bus(REG_TTE, w[8], 1'b1);
    bus(REG_VOLT, VOLT_MAX_MV, 1'b1);
    @(negedge clk_in) f[13] = 1'b1;
    bus(REG_TEMP, 16'h0BB8, 1'b0);
    bus(REG_TEMP, 16'h0BB8, 1'b1);
    @(negedge clk_in) f[13] = 1'b0;
    bus(REG_TEMP, w[1], 1'b1);
    bus(REG_STBY, 16'h000A, 1'b1);
    cq(CMD_CHEM, CHEM);
    cq(CMD_REV, 16'h0000);
    cq(CMD_HIB_SET, 16'h0040);
    @(negedge clk_in) f[9] = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(16'(hib), 16'h0001);
    cq(CMD_HIB_CLR, 16'h0000);
    chk(16'(hib), 16'h0000);
    @(negedge clk_in) f[9] = 1'b0;
    cq(CMD_REST, 16'h0000);
    @(negedge clk_in) f[0] = 1'b1;
    bus(REG_RATE, 16'h0000, 1'b0);
    bus(REG_CTRL, CMD_REST, 1'b0);
    repeat (250) @(negedge clk_in);
    chk(16'(n_meas), 16'h0001);
    chk(16'(n_soc), 16'h0002);
    bus(REG_TTE_RATE, WORD_NONE, 1'b1);
    cq(CMD_STATUS, 16'h0280);
    @(negedge clk_in) f[3] = 1'b1;
    cq(CMD_REST, 16'h0180);
    @(negedge clk_in) f[7:3] = 5'h18;
    bus(REG_CTRL, CMD_INSERT, 1'b0);
    bus(REG_FLAGS, 16'h000F, 1'b1);
    chk(16'(n_soc), 16'h0003);
    bus(REG_CTRL, CMD_REMOVE, 1'b0);
    bus(REG_FLAGS, 16'h0007, 1'b1);
    @(negedge clk_in) irq_en = 1'b0;
    bus(REG_FLAGS, 16'h0003, 1'b1);
    @(negedge clk_in) f[7:3] = 5'h00;
    cq(CMD_LEARN, 16'h0181);
    chk(acc, 16'h0190);
    @(negedge clk_in) f[11] = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(acc, 16'h0000);
    @(negedge clk_in) f[11] = 1'b0;
    bus(REG_CTRL, CMD_RESET, 1'b0);
    chk(16'(n_rst), 16'h0001);
    cq(CMD_SEAL, 16'h2080);
    cq(CMD_LEARN, 16'h2080);
    bus(REG_CTRL, CMD_RESET, 1'b0);
    chk(16'(n_rst), 16'h0001);
    final_report(0);
  end
endmodule
`default_nettype wire
